// ---- shp_pkg.sv ----
// Constants shared by the two-wire host register port
package shp_pkg;
    // Upper six bits of the seven-bit slave address
    localparam logic [5:0] SHP_ADDR_HI = 6'h34;
    localparam int SHP_BYTE_BITS = 8;
    localparam logic [3:0] SHP_LAST_BIT = 4'h8;
    localparam logic [3:0] SHP_FIRST_OUT = 4'h1;
    localparam logic [3:0] SHP_BIT_ZERO = 4'h0;
    localparam int SHP_INDEX_BITS = 8;
    localparam logic [7:0] SHP_INDEX_RST = 8'h00;
    localparam logic [7:0] SHP_INDEX_STEP = 8'h01;
    localparam logic SHP_DIR_READ = 1'b1;
    // Bus rate limit the block is sized for
    localparam int SHP_BUS_KHZ = 400;
    localparam int SHP_ALT_BUS_KHZ = 1000;

    typedef enum logic [3:0] {
        SHP_IDLE,
        SHP_ADDR,
        SHP_ADDR_ACK,
        SHP_REG,
        SHP_REG_ACK,
        SHP_WDATA,
        SHP_WDATA_ACK,
        SHP_RLOAD,
        SHP_RDATA,
        SHP_RACK,
        SHP_IGNORE
    } shp_state_e;
endpackage : shp_pkg

// ---- shp_host_port.sv ----
// Two-wire bus slave giving a system processor access to the register file
//
// Notes on behaviour
// [R1] Register access over two-wire bus, 400 kHz
// [R2] Disable bit latched; two-wire mode then stays off
// [R3] Acts only as slave; never masters bus
// [R4] Seven-bit address, LSB from select pin
// [R5] SDA fall, SCL high: start, bus busy
// [R6] SDA rise, SCL high: stop, bus free
// [R7] Repeated start: stay busy, decode address
// [R8] Eight-bit bytes, unlimited count per transfer
// [R9] Receiver pulls SDA low on ninth clock
// [R10] Slave stretches SCL low until ready
// [R11] Master sends address then direction bit
// [R12] Master ends with stop or repeated start
// [R13] SDA changes only while SCL low
// [R14] Write: address, index, data, each acknowledged
// [R15] Further write bytes go to next index
// [R16] Read: index write, restart, read address
// [R17] Master ends read with NACK, stop
// [R18] Foreign address: no ACK, idle until start
// [R19] Index advances after each byte sent
`timescale 1ns/1ns
module shp_host_port
    import shp_pkg::*;
#(
    parameter int INDEX_BITS = SHP_INDEX_BITS
) (
    // Clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Two-wire pins (open drain, oe high pulls low)
    input wire logic i_scl,
    output logic o_scl_out,
    output logic o_scl_oe,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_address_select_pin,
    // Mode control
    input wire logic i_twowire_host_port_disable,
    output logic o_busy,
    // Register file write side
    output logic o_wr_en,
    output logic [INDEX_BITS-1:0] o_wr_index,
    output logic [7:0] o_wr_data,
    // Register file read side
    output logic o_rd_req,
    output logic [INDEX_BITS-1:0] o_rd_index,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_valid
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
    logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
    logic sel_meta_reg, sel_sync_reg;
    logic dis_meta_reg, dis_sync_reg;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            sel_meta_reg <= 1'b0;
            sel_sync_reg <= 1'b0;
            dis_meta_reg <= 1'b0;
            dis_sync_reg <= 1'b0;
        end else if (i_ce) begin
            scl_meta_reg <= i_scl; // [R1]
            scl_sync_reg <= scl_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_meta_reg <= i_sda;
            sda_sync_reg <= sda_meta_reg;
            sda_prev_reg <= sda_sync_reg;
            sel_meta_reg <= i_address_select_pin;
            sel_sync_reg <= sel_meta_reg;
            dis_meta_reg <= i_twowire_host_port_disable;
            dis_sync_reg <= dis_meta_reg;
        end
    end

    logic scl_rise, scl_fall, start_seen, stop_seen;
    assign scl_rise = scl_sync_reg & ~scl_prev_reg;
    assign scl_fall = ~scl_sync_reg & scl_prev_reg;
    // SDA moves only with SCL low except at start and stop [R13]
    assign start_seen = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg; // [R5]
    assign stop_seen = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg; // [R6]

    // ------------------------------------------------------------
    // Two-wire disable latch
    // ------------------------------------------------------------
    // Sticky until reset so a four-wire burst never looks like a start
    logic off_reg;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            off_reg <= 1'b0;
        end else if (i_ce && dis_sync_reg) begin
            off_reg <= 1'b1; // [R2]
        end
    end

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    shp_state_e state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic rw_reg;
    logic [INDEX_BITS-1:0] index_reg;
    logic [6:0] own_addr;
    assign own_addr = {SHP_ADDR_HI, sel_sync_reg}; // [R4]

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= SHP_IDLE;
            bit_cnt_reg <= SHP_BIT_ZERO;
            shift_reg <= 8'h00;
            rw_reg <= 1'b0;
            index_reg <= INDEX_BITS'(SHP_INDEX_RST);
            o_sda_oe <= 1'b0;
            o_scl_oe <= 1'b0;
            o_sda_out <= 1'b0;
            o_scl_out <= 1'b0;
            o_busy <= 1'b0;
            o_wr_en <= 1'b0;
            o_wr_index <= INDEX_BITS'(SHP_INDEX_RST);
            o_wr_data <= 8'h00;
            o_rd_req <= 1'b0;
            o_rd_index <= INDEX_BITS'(SHP_INDEX_RST);
        end else if (i_ce) begin
            o_wr_en <= 1'b0;
            o_rd_req <= 1'b0;
            if (off_reg) begin
                state_reg <= SHP_IDLE; // [R2]
                o_sda_oe <= 1'b0;
                o_scl_oe <= 1'b0;
                o_busy <= 1'b0;
            end else if (start_seen) begin
                state_reg <= SHP_ADDR; // [R5] [R7]
                bit_cnt_reg <= SHP_BIT_ZERO;
                o_busy <= 1'b1;
                o_sda_oe <= 1'b0;
                o_scl_oe <= 1'b0;
            end else if (stop_seen) begin
                state_reg <= SHP_IDLE; // [R6]
                o_busy <= 1'b0;
                o_sda_oe <= 1'b0;
                o_scl_oe <= 1'b0;
            end else begin
                case (state_reg)
                    SHP_ADDR, SHP_REG, SHP_WDATA: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_sync_reg}; // [R8]
                            bit_cnt_reg <= bit_cnt_reg + SHP_FIRST_OUT;
                        end else if (scl_fall && bit_cnt_reg == SHP_LAST_BIT) begin
                            bit_cnt_reg <= SHP_BIT_ZERO;
                            if (state_reg == SHP_ADDR) begin
                                // Address then direction bit [R11]
                                if (shift_reg[7:1] == own_addr) begin
                                    rw_reg <= shift_reg[0];
                                    o_sda_oe <= 1'b1; // [R9]
                                    state_reg <= SHP_ADDR_ACK;
                                end else begin
                                    state_reg <= SHP_IGNORE; // [R18]
                                end
                            end else if (state_reg == SHP_REG) begin
                                index_reg <= INDEX_BITS'(shift_reg); // [R14]
                                o_sda_oe <= 1'b1; // [R9]
                                state_reg <= SHP_REG_ACK;
                            end else begin
                                o_wr_en <= 1'b1; // [R14]
                                o_wr_index <= index_reg;
                                o_wr_data <= shift_reg;
                                index_reg <= index_reg + INDEX_BITS'(SHP_INDEX_STEP); // [R15]
                                o_sda_oe <= 1'b1; // [R9]
                                state_reg <= SHP_WDATA_ACK;
                            end
                        end
                    end
                    SHP_ADDR_ACK: begin
                        if (scl_fall) begin
                            o_sda_oe <= 1'b0;
                            if (rw_reg == SHP_DIR_READ) begin
                                state_reg <= SHP_RLOAD; // [R16]
                                o_scl_oe <= 1'b1; // [R10]
                                o_rd_req <= 1'b1;
                                o_rd_index <= index_reg;
                            end else begin
                                state_reg <= SHP_REG;
                            end
                        end
                    end
                    SHP_REG_ACK, SHP_WDATA_ACK: begin
                        if (scl_fall) begin
                            o_sda_oe <= 1'b0;
                            state_reg <= SHP_WDATA; // [R15]
                        end
                    end
                    SHP_RLOAD: begin
                        // Hold SCL low until the register file answers [R10]
                        if (i_rd_valid) begin
                            shift_reg <= {i_rd_data[6:0], 1'b0};
                            o_sda_oe <= ~i_rd_data[7];
                            bit_cnt_reg <= SHP_FIRST_OUT;
                            state_reg <= SHP_RDATA;
                        end
                    end
                    SHP_RDATA: begin
                        if (o_scl_oe) begin
                            // Data bit settles a cycle before the clock is let go [R13]
                            o_scl_oe <= 1'b0; // [R10]
                        end else if (scl_fall) begin
                            if (bit_cnt_reg == SHP_LAST_BIT) begin
                                o_sda_oe <= 1'b0; // Master drives ack
                                state_reg <= SHP_RACK;
                                index_reg <= index_reg + INDEX_BITS'(SHP_INDEX_STEP); // [R19]
                            end else begin
                                o_sda_oe <= ~shift_reg[7]; // [R13]
                                shift_reg <= {shift_reg[6:0], 1'b0};
                                bit_cnt_reg <= bit_cnt_reg + SHP_FIRST_OUT;
                            end
                        end
                    end
                    SHP_RACK: begin
                        if (scl_rise) begin
                            rw_reg <= ~sda_sync_reg; // Low means master wants more
                        end else if (scl_fall) begin
                            if (rw_reg) begin
                                state_reg <= SHP_RLOAD;
                                o_scl_oe <= 1'b1; // [R10]
                                o_rd_req <= 1'b1;
                                o_rd_index <= index_reg;
                            end else begin
                                state_reg <= SHP_IGNORE; // [R17]
                            end
                        end
                    end
                    default: begin
                        o_sda_oe <= 1'b0; // [R3] [R18]
                        o_scl_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule : shp_host_port

// ---- shp_host_port_assertions.sv ----
// Bound checker for the two-wire host register port
`timescale 1ns/1ns
module shp_host_port_assertions
    import shp_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Bus and control inputs
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_twowire_host_port_disable,
    input wire logic i_rd_valid,
    // Outputs watched
    input wire logic o_scl_oe,
    input wire logic o_sda_oe,
    input wire logic o_busy,
    input wire logic o_wr_en,
    input wire logic o_rd_req
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // Sticky copy of the disable pin
    logic dis_seen_reg;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) dis_seen_reg <= 1'b0;
        else dis_seen_reg <= dis_seen_reg | i_twowire_host_port_disable;
    end
    property p_dis; $past(dis_seen_reg, 5) |-> !o_sda_oe && !o_scl_oe; endproperty
    a_dis: assert property (p_dis) else $error("port drives while disabled");
    property p_start; $fell(i_sda) && i_scl && $past(i_scl) && !dis_seen_reg |-> ##[1:5] o_busy; endproperty
    a_start: assert property (p_start) else $error("start not seen");
    property p_stop; $rose(i_sda) && i_scl && $past(i_scl) |-> ##[1:5] !o_busy; endproperty
    a_stop: assert property (p_stop) else $error("stop not seen");
    // Raw clock is low for many cycles around each data change
    property p_sda_chg; $changed(o_sda_oe) |-> !i_scl; endproperty
    a_sda_chg: assert property (p_sda_chg) else $error("data moved with clock high");
    property p_rd_req; o_rd_req |-> o_scl_oe ##1 !o_rd_req; endproperty
    a_rd_req: assert property (p_rd_req) else $error("read fetch not stretched");
    property p_hold; o_scl_oe && !i_rd_valid && !$past(i_rd_valid) |=> o_scl_oe; endproperty
    a_hold: assert property (p_hold) else $error("stretch dropped early");
    // Release lags the fetch by one cycle so the first data bit is already set
    property p_rel; o_scl_oe && i_rd_valid |-> ##2 !o_scl_oe; endproperty
    a_rel: assert property (p_rel) else $error("stretch not released");
    property p_wr; o_wr_en |-> ##1 (!o_wr_en && o_sda_oe); endproperty
    a_wr: assert property (p_wr) else $error("write byte not acknowledged");
    c_wr: cover property (o_wr_en);
    c_rd: cover property (o_rd_req);
    c_dis: cover property (dis_seen_reg && o_busy == 1'b0);
endmodule : shp_host_port_assertions

bind shp_host_port shp_host_port_assertions u_chk (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_scl(i_scl), .i_sda(i_sda), .i_twowire_host_port_disable(i_twowire_host_port_disable),
    .i_rd_valid(i_rd_valid), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe), .o_busy(o_busy),
    .o_wr_en(o_wr_en), .o_rd_req(o_rd_req));

// ---- shp_master_model.sv ----
// Bus master model on the far side of the host port
`timescale 1ns/1ns
module shp_master_model (
    // Clock and wire levels
    input wire logic i_mclk,
    input wire logic i_scl,
    input wire logic i_sda,
    // Open-drain pulls
    output logic o_scl_low,
    output logic o_sda_low
);
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end
    task automatic hp();
        repeat (6) @(negedge i_mclk);
    endtask : hp
    // One cycle after the clock falls, so data never races the clock edge
    task automatic bit_io(input logic b, output logic r);
        @(negedge i_mclk);
        o_sda_low = ~b;
        // Six cycles low and six high give a 48 ns bit
        repeat (5) @(negedge i_mclk);
        o_scl_low = 1'b0;
        for (int n = 0; n < 400 && i_scl !== 1'b1; n++) @(negedge i_mclk);
        hp();
        r = i_sda;
        o_scl_low = 1'b1;
    endtask : bit_io
    task automatic start();
        // Data let go while the clock is low, so a repeated start sees a clean high
        @(negedge i_mclk);
        o_sda_low = 1'b0;
        repeat (5) @(negedge i_mclk);
        o_scl_low = 1'b0;
        for (int n = 0; n < 400 && i_scl !== 1'b1; n++) @(negedge i_mclk);
        hp();
        o_sda_low = 1'b1;
        hp();
        o_scl_low = 1'b1;
    endtask : start
    task automatic stop();
        @(negedge i_mclk);
        o_sda_low = 1'b1;
        hp();
        o_scl_low = 1'b0;
        hp();
        o_sda_low = 1'b0;
        hp();
    endtask : stop
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wbyte
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(~ack, r);
    endtask : rbyte
endmodule : shp_master_model

// ---- tb_shp_host_port.sv ----
// Testbench for the two-wire host register port
`timescale 1ns/1ns
module tb_shp_host_port;
    import shp_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, pin = 1'b0, dis = 1'b0, rd_valid = 1'b0;
    logic [7:0] rd_data = 8'h00, wr_index, wr_data, rd_index;
    logic [3:0] rd_dly = 4'h0;
    logic scl_low, sda_low, scl_oe, sda_oe, scl_out, sda_out, busy, wr_en, rd_req, ack;
    logic [7:0] mem [256];
    int err_count = 0, samples_checked = 0;
    wire logic scl = ~(scl_low | scl_oe);
    wire logic sda = ~(sda_low | sda_oe);
    always #2 clk = ~clk;
    shp_host_port DUT (.i_mclk(clk), .i_rst(rst), .i_ce(ce), .i_scl(scl), .o_scl_out(scl_out),
        .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_address_select_pin(pin), .i_twowire_host_port_disable(dis), .o_busy(busy),
        .o_wr_en(wr_en), .o_wr_index(wr_index), .o_wr_data(wr_data), .o_rd_req(rd_req),
        .o_rd_index(rd_index), .i_rd_data(rd_data), .i_rd_valid(rd_valid));
    shp_master_model m (.i_mclk(clk), .i_scl(scl), .i_sda(sda), .o_scl_low(scl_low),
        .o_sda_low(sda_low));
    // Register file answers late so every read byte is stretched
    always @(posedge clk) if (wr_en) mem[wr_index] <= wr_data;
    always @(negedge clk) begin
        rd_dly <= {rd_dly[2:0], rd_req};
        rd_valid <= rd_dly[3];
        rd_data <= mem[rd_index];
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run
    task automatic addr(input logic [6:0] a, input logic rd, input logic exp_ack);
        m.start();
        m.wbyte({a, rd}, ack);
        chk({7'h0, ack}, {7'h0, exp_ack});
    endtask : addr
    task automatic t_burst_write();
        addr({SHP_ADDR_HI, 1'b0}, 1'b0, 1'b1);
        chk({7'h0, busy}, 8'h01);
        m.wbyte(8'hfe, ack);
        for (int i = 0; i < 3; i++) begin
            m.wbyte(8'(8'ha1 + 8'h11 * i), ack);
            chk({7'h0, ack}, 8'h01);
        end
        m.stop();
        chk({7'h0, busy}, 8'h00);
        chk(mem[8'h00], 8'hc3);
        // Open-drain clock and data outputs must never carry a high level
        chk({6'h00, scl_out, sda_out}, 8'h00);
    endtask : t_burst_write
    task automatic t_burst_read();
        logic [7:0] d;
        addr({SHP_ADDR_HI, 1'b0}, 1'b0, 1'b1);
        m.wbyte(8'hfe, ack);
        addr({SHP_ADDR_HI, 1'b0}, SHP_DIR_READ, 1'b1);
        for (int i = 0; i < 3; i++) begin
            m.rbyte(i < 2, d);
            chk(d, 8'(8'ha1 + 8'h11 * i));
        end
        m.stop();
    endtask : t_burst_read
    task automatic t_foreign();
        pin = 1'b1;
        addr({SHP_ADDR_HI, 1'b0}, 1'b0, 1'b0);
        m.stop();
        addr({SHP_ADDR_HI, 1'b1}, 1'b0, 1'b1);
        m.wbyte(8'h10, ack);
        m.wbyte(8'h77, ack);
        m.stop();
        chk(mem[8'h10], 8'h77);
    endtask : t_foreign
    task automatic t_disable();
        dis = 1'b1;
        addr({SHP_ADDR_HI, 1'b1}, 1'b0, 1'b0);
        m.stop();
        dis = 1'b0;
        addr({SHP_ADDR_HI, 1'b1}, 1'b0, 1'b0);
        m.stop();
    endtask : t_disable
    initial begin
        #200000;
        err_count++;
        complete_run();
    end
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_burst_write();
        t_burst_read();
        t_foreign();
        t_disable();
        complete_run();
    end
endmodule : tb_shp_host_port
